// ### logic/rst_regs.svh
// offsets, field positions, reset values and timing counts of the reset block
// assumes: included by bare name from the top module; 50 MHz aclk
//
// Function
// RL1: supply below power-on level asserts reset
// RL2: power-on release starts delay, reset held
// RL3: long pin low resets, short ignored
// RL4: pin release runs delay before core release
// RL5: level code 111 disables brown-out detection
// RL6: enabled brown-out with low supply resets
// RL7: brown-out counts only after 2 us low
// RL8: brown-out release runs delay, then release
// RL9: watchdog reset is one-clock pulse, then delay
// RL10: cause flags set by source, cleared by software/power
// RL11: power-up flag cleared only by software zero
// RL12: reference on for brown-out, comparator, converters
// RL13: software waits 40 us for reference start
// RL14: watchdog counts 128 kHz oscillator to timeout
// RL15: restart clears counter before timeout
// RL16: interrupt mode raises request, no reset
// RL17: reset mode resets; combined mode irq then reset
// RL18: always-on fuse forces reset-only mode
// RL19: software opens window writing change and enable
// RL20: software writes new setting within four cycles
// RL21: change window closes four cycles after opening
// RL22: reset-enable held while watchdog cause set
// RL23: prescaler 2048 cycles doubling up to code 1001
// RL24: irq flag set on timeout, cleared by vector/one
// RL25: protected changes ignored outside change window
// RL26: delay length is input; any reset restarts it
`ifndef RST_REGS_SVH
`define RST_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CAUSE_OFS 8'h00
`define WDT_CTRL_OFS 8'h04
`define REF_CTRL_OFS 8'h08

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CAUSE_WDT 3
`define CAUSE_BOD 2
`define CAUSE_PIN 1
`define CAUSE_POR 0
`define CAUSE_RST 4'h1
`define PIN_IDLE 3'h7
`define WC_IF 7
`define WC_IE 6
`define WC_P3 5
`define WC_CE 4
`define WC_RE 3
`define RC_COMPARATOR_REFERENCE_SELECT 0
`define RC_ON 7
`define BOD_OFF 3'h7
`define WDP_MAX 4'h9
`define WIN_CYC 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 50
`define PIN_MIN_NS 2500
`define BOD_MIN_NS 2000
`define PIN_MIN_CYC ((`PIN_MIN_NS * `CLK_MHZ + 999) / 1000)
`define BOD_MIN_CYC ((`BOD_MIN_NS * `CLK_MHZ + 999) / 1000)
`define WDT_BASE_CYC 21'h000800

`endif

// ### logic/rst_pkg.sv
// types of the reset and watchdog block
// assumes: compiled before the top module
package rst_pkg;
   localparam int STARTUP_W = 24;

   typedef enum logic [1:0] {
      SEQ_HOLD = 2'b00,
      SEQ_DELAY = 2'b01,
      SEQ_RUN = 2'b10
   } seq_t;

   typedef struct packed {
      logic [2:0] por_s, pin_s, bod_s, osc_s;
      logic por_lvl, osc_lvl;
      logic [7:0] pin_cnt, bod_cnt;
      seq_t seq;
      logic [STARTUP_W-1:0] dly;
      logic core_rst, wdt_pulse;
      logic [3:0] cause;
      logic watchdog_irq_flag, watchdog_irq_enable, watchdog_reset_enable, comparator_reference_select, ref_on, bod_on;
      logic [3:0] watchdog_prescale_select;
      logic [2:0] win;
      logic [20:0] wcnt;
      logic aw_ok, w_ok, aw_rdy, w_rdy, ar_rdy, bvalid, rvalid, wstrb0;
      logic [7:0] awaddr, wdata, rdata;
      logic [1:0] bresp, rresp;
   } state_t;
endpackage : rst_pkg

// ### logic/reset_sources_and_watchdog.sv
// reset source combiner, start-up stretcher, cause flags and watchdog
// assumes: analog detector levels, pin and watchdog oscillator arrive
// asynchronously; fuses and converter enables are static or aclk-timed
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`include "rst_regs.svh"

module reset_sources_and_watchdog #(
   parameter logic [20:0] WDT_BASE = `WDT_BASE_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // analog detectors, pin, oscillator
   input wire logic por_low,
   input wire logic pin_reset_n,
   input wire logic bod_low,
   input wire logic wdt_osc,
   // fuses and configuration
   input wire logic [2:0] brownout_level_select,
   input wire logic watchdog_always_on_fuse,
   input wire logic [rst_pkg::STARTUP_W-1:0] startup_delay_period,
   // core side
   input wire logic wdt_restart,
   input wire logic wdt_vector_taken,
   input wire logic adc_enable,
   input wire logic dac_enable,
   // results
   output logic core_reset,
   output logic wdt_reset_pulse,
   output logic wdt_irq,
   output logic ref_enable,
   output logic brownout_enable
);

   localparam logic [7:0] PIN_MIN = 8'(`PIN_MIN_CYC);
   localparam logic [7:0] BOD_MIN = 8'(`BOD_MIN_CYC);
   localparam logic [rst_pkg::STARTUP_W-1:0] DLY_ONE = {{(rst_pkg::STARTUP_W-1){1'b0}}, 1'b1};

   rst_pkg::state_t st_r, st_nxt;
   logic pin_act, bod_act, src_act, osc_edge, expire, running;
   logic eff_wde, eff_watchdog_irq_enable, wr_go, wr_hit;
   logic wr_cause, wr_ctrl, wr_ref;
   logic [3:0] wdp_eff;
   logic [20:0] timeout;
   logic [7:0] wa, ra;
   logic [7:0] d;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      d = st_r.wdata;
      wa = {st_r.awaddr[7:2], 2'h0};
      ra = {araddr[7:2], 2'h0};

      // three-stage synchronisers; only stages 2 and 3 are looked at
      st_nxt.por_s = {st_r.por_s[1:0], por_low};
      st_nxt.pin_s = {st_r.pin_s[1:0], pin_reset_n};
      st_nxt.bod_s = {st_r.bod_s[1:0], bod_low};
      st_nxt.osc_s = {st_r.osc_s[1:0], wdt_osc};
      if (st_r.por_s[1] == st_r.por_s[2]) begin
         st_nxt.por_lvl = st_r.por_s[2];
      end
      osc_edge = (st_r.osc_s[1] == st_r.osc_s[2]) && st_r.osc_s[2] && !st_r.osc_lvl;
      if (st_r.osc_s[1] == st_r.osc_s[2]) begin
         st_nxt.osc_lvl = st_r.osc_s[2];
      end

      // pin low must persist before it counts
      if (st_r.pin_s[1] == st_r.pin_s[2]) begin
         if (st_r.pin_s[2]) begin
            st_nxt.pin_cnt = 8'h00; // [RL4]
         end else if (st_r.pin_cnt != PIN_MIN) begin
            st_nxt.pin_cnt = st_r.pin_cnt + 8'h01; // [RL3]
         end
      end
      pin_act = st_r.pin_cnt == PIN_MIN;

      // brown-out: enabled by level code, short dips filtered out
      st_nxt.bod_on = brownout_level_select != `BOD_OFF; // [RL5]
      if (!st_r.bod_on) begin
         st_nxt.bod_cnt = 8'h00;
      end else if (st_r.bod_s[1] == st_r.bod_s[2]) begin
         if (!st_r.bod_s[2]) begin
            st_nxt.bod_cnt = 8'h00; // [RL8]
         end else if (st_r.bod_cnt != BOD_MIN) begin
            st_nxt.bod_cnt = st_r.bod_cnt + 8'h01; // [RL7]
         end
      end
      bod_act = st_r.bod_on && (st_r.bod_cnt == BOD_MIN); // [RL6]

      // ----------------------------------------------------------------
      // reset sequencer: any source holds, release restarts the delay
      // ----------------------------------------------------------------
      src_act = st_r.por_lvl || pin_act || bod_act || st_r.wdt_pulse; // [RL1]
      case (st_r.seq)
         rst_pkg::SEQ_HOLD: begin
            if (!src_act) begin
               st_nxt.seq = rst_pkg::SEQ_DELAY;
               st_nxt.dly = startup_delay_period; // [RL26] [RL2]
            end
         end
         rst_pkg::SEQ_DELAY: begin
            if (src_act) begin
               st_nxt.seq = rst_pkg::SEQ_HOLD; // [RL26]
            end else if (st_r.dly == '0) begin
               st_nxt.seq = rst_pkg::SEQ_RUN;
               st_nxt.core_rst = 1'b0; // [RL2] [RL4] [RL8]
            end else begin
               st_nxt.dly = st_r.dly - DLY_ONE;
            end
         end
         rst_pkg::SEQ_RUN: begin
            if (src_act) begin
               st_nxt.seq = rst_pkg::SEQ_HOLD;
            end
         end
         default: begin
            st_nxt.seq = rst_pkg::SEQ_HOLD;
         end
      endcase
      if (src_act) begin
         st_nxt.core_rst = 1'b1; // [RL1] [RL6]
      end

      // ----------------------------------------------------------------
      // watchdog counter on the slow oscillator
      // ----------------------------------------------------------------
      eff_wde = st_r.watchdog_reset_enable || st_r.cause[`CAUSE_WDT] || watchdog_always_on_fuse; // [RL22] [RL18]
      eff_watchdog_irq_enable = st_r.watchdog_irq_enable && !watchdog_always_on_fuse; // [RL18]
      running = eff_wde || eff_watchdog_irq_enable;
      // reserved codes behave as the longest period
      wdp_eff = (st_r.watchdog_prescale_select > `WDP_MAX) ? `WDP_MAX : st_r.watchdog_prescale_select; // [RL23]
      timeout = WDT_BASE << wdp_eff; // [RL23]
      expire = 1'b0;
      if (st_r.core_rst || wdt_restart || !running) begin
         st_nxt.wcnt = 21'h000000; // [RL15]
      end else if (osc_edge) begin
         if (st_r.wcnt == timeout - 21'h000001) begin
            st_nxt.wcnt = 21'h000000;
            expire = 1'b1; // [RL14]
         end else begin
            st_nxt.wcnt = st_r.wcnt + 21'h000001; // [RL14]
         end
      end
      st_nxt.wdt_pulse = expire && eff_wde && !eff_watchdog_irq_enable; // [RL17] [RL9]

      // ----------------------------------------------------------------
      // axi4-lite slave
      // ----------------------------------------------------------------
      if (awvalid && st_r.aw_rdy) begin
         st_nxt.aw_ok = 1'b1;
         st_nxt.awaddr = awaddr;
      end
      if (wvalid && st_r.w_rdy) begin
         st_nxt.w_ok = 1'b1;
         st_nxt.wdata = wdata[7:0];
         st_nxt.wstrb0 = wstrb[0];
      end
      wr_go = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
      wr_hit = (wa == `CAUSE_OFS) || (wa == `WDT_CTRL_OFS) || (wa == `REF_CTRL_OFS);
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (wr_go) begin
         st_nxt.aw_ok = 1'b0;
         st_nxt.w_ok = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      wr_cause = wr_go && st_r.wstrb0 && (wa == `CAUSE_OFS);
      wr_ctrl = wr_go && st_r.wstrb0 && (wa == `WDT_CTRL_OFS);
      wr_ref = wr_go && st_r.wstrb0 && (wa == `REF_CTRL_OFS);

      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (arvalid && st_r.ar_rdy) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `RESP_OKAY;
         case (ra)
            `CAUSE_OFS: st_nxt.rdata = {4'h0, st_r.cause};
            `WDT_CTRL_OFS: st_nxt.rdata = {st_r.watchdog_irq_flag, eff_watchdog_irq_enable, st_r.watchdog_prescale_select[3], st_r.win != 3'h0,
                                           eff_wde, st_r.watchdog_prescale_select[2:0]}; // [RL22]
            `REF_CTRL_OFS: st_nxt.rdata = {st_r.ref_on, 6'h00, st_r.comparator_reference_select};
            default: begin
               st_nxt.rdata = 8'h00;
               st_nxt.rresp = `RESP_SLVERR;
            end
         endcase
      end
      st_nxt.aw_rdy = !st_nxt.aw_ok && !st_nxt.bvalid;
      st_nxt.w_rdy = !st_nxt.w_ok && !st_nxt.bvalid;
      st_nxt.ar_rdy = !st_nxt.rvalid;

      // ----------------------------------------------------------------
      // cause flags: software writes zero to clear, a source sets
      // ----------------------------------------------------------------
      if (wr_cause) begin
         st_nxt.cause = st_r.cause & d[3:0]; // [RL10] [RL11]
      end
      // setting after clearing, so a coincident event is never lost
      if (st_r.por_lvl) begin
         st_nxt.cause = `CAUSE_RST; // [RL10] [RL11]
      end else begin
         if (st_r.wdt_pulse) begin
            st_nxt.cause[`CAUSE_WDT] = 1'b1; // [RL10]
         end
         if (bod_act) begin
            st_nxt.cause[`CAUSE_BOD] = 1'b1; // [RL10]
         end
         if (pin_act) begin
            st_nxt.cause[`CAUSE_PIN] = 1'b1; // [RL10]
         end
      end

      // ----------------------------------------------------------------
      // watchdog control and timed change window
      // ----------------------------------------------------------------
      if (st_r.win != 3'h0) begin
         st_nxt.win = st_r.win - 3'h1; // [RL21]
      end
      if (wr_ctrl) begin
         st_nxt.watchdog_irq_enable = d[`WC_IE];
         if (d[`WC_CE] && d[`WC_RE]) begin
            st_nxt.win = `WIN_CYC; // [RL21]
            st_nxt.watchdog_reset_enable = 1'b1;
         end else if (st_r.win != 3'h0) begin
            st_nxt.watchdog_reset_enable = d[`WC_RE];
            st_nxt.watchdog_prescale_select = {d[`WC_P3], d[2:0]};
            st_nxt.win = 3'h0;
         end else begin
            st_nxt.watchdog_reset_enable = st_r.watchdog_reset_enable || d[`WC_RE]; // [RL25]
         end
         if (d[`WC_IF]) begin
            st_nxt.watchdog_irq_flag = 1'b0; // [RL24]
         end
      end
      if (wdt_vector_taken) begin
         st_nxt.watchdog_irq_flag = 1'b0; // [RL24]
         if (eff_wde) begin
            st_nxt.watchdog_irq_enable = 1'b0;
         end
      end
      if (wr_ref) begin
         st_nxt.comparator_reference_select = d[`RC_COMPARATOR_REFERENCE_SELECT];
      end
      // control bits return to defaults while the core is held, except reset enable under the watchdog cause or fuse
      if (st_r.core_rst) begin
         st_nxt.watchdog_irq_enable = 1'b0;
         st_nxt.watchdog_reset_enable = 1'b0;
         st_nxt.watchdog_prescale_select = 4'h0;
         st_nxt.win = 3'h0;
         st_nxt.watchdog_irq_flag = 1'b0;
         st_nxt.comparator_reference_select = 1'b0;
      end
      if (expire && eff_watchdog_irq_enable) begin
         st_nxt.watchdog_irq_flag = 1'b1; // [RL16] [RL24]
         if (eff_wde) begin
            st_nxt.watchdog_irq_enable = 1'b0; // [RL17]
         end
      end
      if (st_nxt.cause[`CAUSE_WDT]) begin
         st_nxt.watchdog_reset_enable = 1'b1; // [RL22]
      end
      if (watchdog_always_on_fuse) begin
         st_nxt.watchdog_reset_enable = 1'b1; // [RL18]
         st_nxt.watchdog_irq_enable = 1'b0;
      end

      st_nxt.ref_on = st_nxt.bod_on || st_nxt.comparator_reference_select || adc_enable || dac_enable; // [RL12]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.core_rst <= 1'b1;
         st_r.cause <= `CAUSE_RST;
         // pin idles high: a zero here would look like a pin low after reset
         st_r.pin_s <= `PIN_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign awready = st_r.aw_rdy;
   assign wready = st_r.w_rdy;
   assign bvalid = st_r.bvalid;
   assign bresp = st_r.bresp;
   assign arready = st_r.ar_rdy;
   assign rvalid = st_r.rvalid;
   assign rresp = st_r.rresp;
   assign rdata = {24'h000000, st_r.rdata};
   assign core_reset = st_r.core_rst;
   assign wdt_reset_pulse = st_r.wdt_pulse;
   assign wdt_irq = st_r.watchdog_irq_flag;
   assign ref_enable = st_r.ref_on;
   assign brownout_enable = st_r.bod_on;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_por_holds: assert property (st_r.por_lvl |=> core_reset) // [RL1]
      else $error("power-on level did not hold reset");
   a_release_held: assert property ($fell(src_act) |-> core_reset) // [RL2]
      else $error("reset dropped with the sources");
   a_pin_sets: assert property (pin_act && !st_r.por_lvl |=> core_reset && st_r.cause[`CAUSE_PIN]) // [RL3]
      else $error("long pin low did not reset");
   a_release_delay: assert property ($fell(core_reset) |->
      $past(st_r.seq) == rst_pkg::SEQ_DELAY && $past(st_r.dly) == '0) // [RL4] [RL8] [RL26]
      else $error("core released before the delay ran out");
   a_bod_off: assert property (brownout_level_select == `BOD_OFF |=> ##1 !bod_act) // [RL5]
      else $error("brown-out active while disabled");
   a_bod_filter: assert property ($rose(bod_act) |-> $past(st_r.bod_cnt) == BOD_MIN - 8'h01) // [RL7]
      else $error("brown-out taken before minimum duration");
   a_wdt_pulse: assert property (wdt_reset_pulse |=> !wdt_reset_pulse && core_reset) // [RL9]
      else $error("watchdog pulse not one cycle");
   a_por_only: assert property (st_r.por_lvl |=> st_r.cause == `CAUSE_RST) // [RL10]
      else $error("power-on did not clear the other flags");
   a_ref_on: assert property (brownout_enable |-> ref_enable) // [RL12]
      else $error("reference off while brown-out enabled");
   a_restart: assert property (wdt_restart |=> st_r.wcnt == 21'h000000) // [RL15]
      else $error("restart did not clear the watchdog");
   a_irq_mode: assert property (expire && eff_watchdog_irq_enable && !eff_wde |=> wdt_irq && !wdt_reset_pulse) // [RL16]
      else $error("interrupt mode misbehaved");
   a_combined: assert property (expire && eff_watchdog_irq_enable && eff_wde |=> !st_r.watchdog_irq_enable && wdt_irq) // [RL17]
      else $error("combined mode did not switch");
   a_fuse_lock: assert property (watchdog_always_on_fuse |=> st_r.watchdog_reset_enable && !st_r.watchdog_irq_enable) // [RL18]
      else $error("fuse did not lock the mode");
   a_win_close: assert property ((st_r.win == `WIN_CYC && !wr_ctrl) ##1 (!wr_ctrl) [*3]
      |=> st_r.win == 3'h0) // [RL21]
      else $error("change window stayed open");
   a_wde_sticky: assert property (st_r.cause[`CAUSE_WDT] |-> st_r.watchdog_reset_enable) // [RL22]
      else $error("reset enable cleared under the cause flag");

   c_wdt_reset: cover property (wdt_reset_pulse ##[1:1000] !core_reset);
   c_wdt_irq: cover property ($rose(wdt_irq));
   c_pin_reset: cover property ($rose(pin_act));
   c_window: cover property (st_r.win == `WIN_CYC ##[1:4] wr_ctrl);

endmodule : reset_sources_and_watchdog

// ### tb/supply_model.sv
// far-side model: analog supply detectors and the watchdog oscillator
// assumes: the bench requests supply dips as levels on aclk edges
module supply_model (
   // requests from the bench
   input wire logic por_req,
   input wire logic bod_req,
   // detector outputs and oscillator
   output logic por_low,
   output logic bod_low,
   output logic wdt_osc
);
   timeunit 1ns;
   timeprecision 1ps;
   // detectors follow the supply level at once, no filtering here
   assign por_low = por_req;
   assign bod_low = bod_req;
   // free-running 128 kHz oscillator, phase unrelated to aclk
   initial begin
      wdt_osc = 1'b0;
      #1.3;
      forever #3906.25 wdt_osc = ~wdt_osc;
   end
endmodule : supply_model

// ### tb/tb_reset_sources_and_watchdog.sv
// bench: register bus master, pin driver and scenario tasks
// assumes: 50 MHz aclk, synchronous aresetn, watchdog base shortened to 4
module tb_reset_sources_and_watchdog;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic por_req = 1'b0, bod_req = 1'b0, pin_reset_n = 1'b1;
   logic por_low, bod_low, wdt_osc;
   logic wdt_restart = 1'b0, adc_enable = 1'b0;
   logic wdt_vector_taken = 1'b0, watchdog_always_on_fuse = 1'b0;
   logic [2:0] brownout_level_select = 3'h6;
   logic core_reset, wdt_reset_pulse, wdt_irq, ref_enable, brownout_enable;
   int error_cnt = 0, total_checks = 0, cyc_cnt = 0;
   logic [31:0] rd_v;
   logic [1:0] rsp;

   reset_sources_and_watchdog #(.WDT_BASE(21'h000004)) i_reset_sources_and_watchdog (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .por_low(por_low), .pin_reset_n(pin_reset_n), .bod_low(bod_low), .wdt_osc(wdt_osc),
      .brownout_level_select(brownout_level_select), .watchdog_always_on_fuse(watchdog_always_on_fuse),
      .startup_delay_period(24'h000008),
      .wdt_restart(wdt_restart), .wdt_vector_taken(wdt_vector_taken),
      .adc_enable(adc_enable), .dac_enable(1'b0),
      .core_reset(core_reset), .wdt_reset_pulse(wdt_reset_pulse), .wdt_irq(wdt_irq),
      .ref_enable(ref_enable), .brownout_enable(brownout_enable)
   );
   supply_model i_supply_model (
      .por_req(por_req), .bod_req(bod_req),
      .por_low(por_low), .bod_low(bod_low), .wdt_osc(wdt_osc)
   );

   initial begin
      forever #10 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // common tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
         error_cnt++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      rsp = bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd_v = rdata;
      rsp = rresp;
   endtask : rd

   // waits for one of the outputs to reach a level, bounded
   task automatic wait_lvl(input int sel, input logic lvl, input int lim, input string what);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (n < lim && (sel == 0 ? core_reset : sel == 1 ? wdt_irq : wdt_reset_pulse) !== lvl);
      chk(n < lim, 1'b1, what);
   endtask : wait_lvl

   // after the last source goes away: held through the delay, then released
   task automatic release_chk();
      repeat (8) @(posedge aclk);
      chk(core_reset, 1'b1, "held during delay");
      wait_lvl(0, 1'b0, 40, "core release");
   endtask : release_chk

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_boot();
      wait_lvl(0, 1'b0, 60, "first release");
      rd(8'h00);
      chk(rd_v, 32'h1, "power-up cause");
      chk({brownout_enable, ref_enable}, 2'b11, "level 110 enables");
      rd(8'h0c);
      chk(rd_v, 32'h0, "unmapped read data");
      chk({30'h0, rsp}, 32'h2, "unmapped read response");
      wr(8'h00, 8'h00);
      rd(8'h00);
      chk(rd_v, 32'h0, "power-up flag cleared by zero");
   endtask : t_boot

   task automatic t_pin_por();
      @(posedge aclk) pin_reset_n <= 1'b0;
      repeat (60) @(posedge aclk);
      pin_reset_n <= 1'b1;
      repeat (20) @(posedge aclk);
      chk(core_reset, 1'b0, "short pin pulse ignored");
      pin_reset_n <= 1'b0;
      wait_lvl(0, 1'b1, 200, "long pin pulse");
      pin_reset_n <= 1'b1;
      release_chk();
      rd(8'h00);
      chk(rd_v, 32'h2, "pin cause");
      por_req <= 1'b1;
      wait_lvl(0, 1'b1, 10, "supply drop resets");
      por_req <= 1'b0;
      release_chk();
      rd(8'h00);
      chk(rd_v, 32'h1, "power-on clears pin cause");
      wr(8'h00, 8'h00);
   endtask : t_pin_por

   task automatic brownout_min_duration();
      @(posedge aclk) bod_req <= 1'b1;
      repeat (50) @(posedge aclk);
      bod_req <= 1'b0;
      repeat (20) @(posedge aclk);
      chk(core_reset, 1'b0, "short dip ignored");
      bod_req <= 1'b1;
      wait_lvl(0, 1'b1, 150, "brown-out reset");
      bod_req <= 1'b0;
      release_chk();
      rd(8'h00);
      chk(rd_v, 32'h4, "brown-out cause");
      wr(8'h00, 8'h00);
      adc_enable <= 1'b1;
      rd(8'h08);
      chk(rd_v[7], 1'b1, "reference on");
      adc_enable <= 1'b0;
      brownout_level_select <= 3'h7;
      repeat (3) @(posedge aclk);
      chk({brownout_enable, ref_enable}, 2'b00, "level 111 disables");
      bod_req <= 1'b1;
      repeat (150) @(posedge aclk);
      chk(core_reset, 1'b0, "no brown-out while disabled");
      bod_req <= 1'b0;
      adc_enable <= 1'b1;
      repeat (2000) @(posedge aclk);
      rd(8'h08);
      chk(rd_v[7], 1'b1, "reference on for converter");
      adc_enable <= 1'b0;
      brownout_level_select <= 3'h6;
   endtask : brownout_min_duration

   task automatic t_wdt_modes();
      wr(8'h04, 8'h40);
      wait_lvl(1, 1'b1, 3000, "irq mode expiry");
      chk(core_reset, 1'b0, "no reset in irq mode");
      wr(8'h04, 8'h80);
      chk(wdt_irq, 1'b0, "irq flag cleared by one");
      wr(8'h04, 8'h48);
      wait_lvl(1, 1'b1, 3000, "combined first expiry");
      chk(core_reset, 1'b0, "combined irq first");
      wdt_vector_taken <= 1'b1;
      @(posedge aclk) wdt_vector_taken <= 1'b0;
      @(posedge aclk);
      chk(wdt_irq, 1'b0, "vector clears irq flag");
      wait_lvl(2, 1'b1, 3000, "combined then reset");
      @(posedge aclk);
      chk(wdt_reset_pulse, 1'b0, "pulse one cycle");
      release_chk();
      rd(8'h00);
      chk(rd_v, 32'h8, "watchdog cause");
      rd(8'h04);
      chk(rd_v[3], 1'b1, "enable held by cause");
   endtask : t_wdt_modes

   task automatic t_restart_window();
      repeat (10) begin
         repeat (400) @(posedge aclk);
         wdt_restart <= 1'b1;
         @(posedge aclk) wdt_restart <= 1'b0;
      end
      chk(core_reset, 1'b0, "restarts avoid reset");
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h08);
      wr(8'h04, 8'h00);
      rd(8'h04);
      chk(rd_v[3], 1'b1, "clear outside window ignored");
      wr(8'h04, 8'h18);
      repeat (8) @(posedge aclk);
      wr(8'h04, 8'h00);
      rd(8'h04);
      chk(rd_v[4:3], 2'b01, "window closed by itself");
      wr(8'h04, 8'h18);
      wr(8'h04, 8'h00);
      rd(8'h04);
      chk(rd_v[4:3], 2'b00, "clear inside window");
      watchdog_always_on_fuse <= 1'b1;
      wr(8'h04, 8'h40);
      rd(8'h04);
      chk(rd_v[6], 1'b0, "fuse holds irq enable off");
      chk(rd_v[3], 1'b1, "fuse holds reset enable");
      wait_lvl(2, 1'b1, 3000, "fuse forces reset mode");
      chk(wdt_irq, 1'b0, "no irq under fuse");
   endtask : t_restart_window

   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 60000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_boot();
      t_pin_por();
      brownout_min_duration();
      t_wdt_modes();
      t_restart_window();
      final_report();
   end
endmodule : tb_reset_sources_and_watchdog
